// *** rtl/hmp_regs.svh ***
// Register addresses, field positions, reset values, read-only masks and buffer depth for the host mailbox port
`ifndef HMP_REGS_SVH
`define HMP_REGS_SVH
`define HMP_ADDR_SYS_CTRL 16'hFFC4
`define HMP_ADDR_HOST_CTRL 16'hFFF0
`define HMP_ADDR_IN_DATA_1 16'hFFF4
`define HMP_ADDR_OUT_DATA_1 16'hFFF5
`define HMP_ADDR_STATUS_1 16'hFFF6
`define HMP_ADDR_IN_DATA_2 16'hFFFC
`define HMP_ADDR_OUT_DATA_2 16'hFFFD
`define HMP_ADDR_STATUS_2 16'hFFFE
`define HMP_ADDR_SER_TMR_CTRL 16'hFFC3
`define HMP_SYS_CTRL_RESET 8'h09
`define HMP_HOST_CTRL_RESET 8'hF8
`define HMP_STATUS_RESET 8'h00
`define HMP_SER_TMR_CTRL_RESET 8'h00
`define HMP_SYS_CTRL_RO_MASK 8'h08
`define HMP_HOST_CTRL_RO_MASK 8'hF8
`define HMP_STATUS_USER_MASK 8'hF4
`define HMP_BIT_PORT_ENABLE 1
`define HMP_BIT_CH1_IRQ_EN 1
`define HMP_BIT_CH2_IRQ_EN 2
`define HMP_BIT_PIN_SWITCH 3
`define HMP_BIT_CMD_DATA 3
`define HMP_BIT_IN_FULL 1
`define HMP_BIT_OUT_FULL 0
`define HMP_BUF_DEPTH 2
`endif

// *** rtl/hmp_pkg.sv ***
// Types shared by the host mailbox port
package hmp_pkg;
   typedef logic [7:0] hmp_byte_t;
   typedef enum logic [1:0] {HMP_ACC_IDLE, HMP_ACC_READ, HMP_ACC_WRITE} hmp_acc_e;
endpackage : hmp_pkg

// *** rtl/hmp_host_port.sv ***
// Two-channel host mailbox port: host pins, slave register bus, flags and interrupt requests
// Functional notes
// - Output data registers: 8 bits, host read-only
// - Drive channel-1 output data on host read
// - Data registers have no defined reset value
// - Channel-1 status clears to zero on reset
// - Status bits 3,1,0 read-only to both
// - Status bits 7-4,2 are slave-writable storage
// - Command/data flag captures address line on write
// - Channel-1 input-full sets on host write
// - Channel-1 input-full clears on slave read
// - Input-full flags request slave interrupts
// - Channel-1 output-full sets on slave write
// - Channel-1 output-full clears on host read
// - Channel-2 host write captures data and address
// - Drive channel-2 output data on host read
// - Channel-2 input-full set/clear like channel 1
// - Channel-2 output-full set/clear like channel 1
// - Channel-2 status clears to zero on reset
// - Pin switch picks primary or alternate pins
// - Pin switch acts only while port enabled
// - Serial/timer control clears to zero on reset
// - Channel-1 host write captures data and address
// - Per-channel enable gates input-full interrupt
// - Host access answered only while port enabled
// - Address-high read returns status; no read+write
`timescale 1ns/10ps
`include "hmp_regs.svh"
module hmp_host_port
   import hmp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic hwStandby,
   input wire logic hostAddrLine,
   input wire logic chan1Select_n,
   input wire logic chan2Select_n,
   input wire logic altChan2Select_n,
   input wire logic hostReadStrobe_n,
   input wire logic hostWriteStrobe_n,
   input wire logic altHostWriteStrobe_n,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   input wire logic [15:0] slvAddr,
   input wire logic slvRd,
   input wire logic slvWr,
   input wire logic [7:0] slvWdata,
   output logic [7:0] slvRdata,
   output logic chan1FullIrq,
   output logic chan2FullIrq,
   output logic inFifoValid,
   input wire logic inFifoReady,
   output logic [8:0] inFifoData,
   output logic inFifoCmd,
   output logic hostWriteReady
);

   logic [7:0] sysCtrl_q;
   logic [7:0] hostCtrl_q;
   logic [7:0] serTmrCtrl_q;
   hmp_byte_t inData_q [2];
   hmp_byte_t outData_q [2];
   logic [7:0] status_q [2];
   logic portEnable;
   logic effSel2_n;
   logic effWr_n;
   logic [1:0] chanSel;
   logic wrPrev_q;
   logic rdPrev_q;
   logic slvRdPrev_q;
   logic slvWrPrev_q;
   logic [15:0] slvAddrPrev_q;
   logic hostWrRise;
   logic hostRdRise;
   logic slvRdFall;
   logic slvWrFall;
   logic [1:0] wrChan_q;
   logic wrAddr_q;
   logic [1:0] rdChan_q;
   logic rdAddr_q;
   logic [8:0] bufData_q [`HMP_BUF_DEPTH];
   logic [1:0] bufCount_q;
   logic bufWrPtr_q;
   logic bufRdPtr_q;
   logic bufPush;
   logic bufPop;

   assign portEnable = sysCtrl_q[`HMP_BIT_PORT_ENABLE];

   // Alternate pins only count while the port is live; otherwise primary pins idle the port anyway
   assign effSel2_n = (portEnable && serTmrCtrl_q[`HMP_BIT_PIN_SWITCH]) ? altChan2Select_n : chan2Select_n;
   assign effWr_n = (portEnable && serTmrCtrl_q[`HMP_BIT_PIN_SWITCH]) ? altHostWriteStrobe_n : hostWriteStrobe_n;

   assign chanSel = portEnable ? {~effSel2_n & chan1Select_n, ~chan1Select_n & effSel2_n} : 2'h0;

   // Host read drive: data on address low, status on address high
   always_comb begin
      hostDataOut = 8'h00;
      hostDataOe = 1'b0;
      if (!hostReadStrobe_n && effWr_n && chanSel != 2'h0) begin
         hostDataOe = 1'b1;
         if (chanSel[0]) begin
            hostDataOut = hostAddrLine ? status_q[0] : outData_q[0];
         end else begin
            hostDataOut = hostAddrLine ? status_q[1] : outData_q[1];
         end
      end
   end

   // Strobe history; the access target is held while the strobe is low so the rising edge knows it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wrPrev_q <= 1'b1;
         rdPrev_q <= 1'b1;
         slvRdPrev_q <= 1'b0;
         slvWrPrev_q <= 1'b0;
         slvAddrPrev_q <= 16'h0000;
         wrChan_q <= 2'h0;
         wrAddr_q <= 1'b0;
         rdChan_q <= 2'h0;
         rdAddr_q <= 1'b0;
      end else begin
         wrPrev_q <= effWr_n;
         rdPrev_q <= hostReadStrobe_n;
         slvRdPrev_q <= slvRd;
         slvWrPrev_q <= slvWr;
         slvAddrPrev_q <= slvAddr;
         if (!effWr_n && hostReadStrobe_n) begin
            wrChan_q <= chanSel;
            wrAddr_q <= hostAddrLine;
         end else if (effWr_n) begin
            wrChan_q <= 2'h0;
         end
         if (!hostReadStrobe_n && effWr_n) begin
            rdChan_q <= chanSel;
            rdAddr_q <= hostAddrLine;
         end else if (hostReadStrobe_n) begin
            rdChan_q <= 2'h0;
         end
      end
   end

   assign hostWrRise = effWr_n && !wrPrev_q;
   assign hostRdRise = hostReadStrobe_n && !rdPrev_q;
   assign slvRdFall = !slvRd && slvRdPrev_q;
   assign slvWrFall = !slvWr && slvWrPrev_q;

   // Control registers; bits marked read-only keep their reset value
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sysCtrl_q <= `HMP_SYS_CTRL_RESET;
         hostCtrl_q <= `HMP_HOST_CTRL_RESET;
         serTmrCtrl_q <= `HMP_SER_TMR_CTRL_RESET;
      end else if (hwStandby) begin
         sysCtrl_q <= `HMP_SYS_CTRL_RESET;
         hostCtrl_q <= `HMP_HOST_CTRL_RESET;
         serTmrCtrl_q <= `HMP_SER_TMR_CTRL_RESET;
      end else if (slvWr) begin
         case (slvAddr)
            `HMP_ADDR_SYS_CTRL: sysCtrl_q <= (sysCtrl_q & `HMP_SYS_CTRL_RO_MASK) |
               (slvWdata & ~`HMP_SYS_CTRL_RO_MASK);
            `HMP_ADDR_HOST_CTRL: hostCtrl_q <= (hostCtrl_q & `HMP_HOST_CTRL_RO_MASK) |
               (slvWdata & ~`HMP_HOST_CTRL_RO_MASK);
            `HMP_ADDR_SER_TMR_CTRL: serTmrCtrl_q <= slvWdata;
            default: ;
         endcase
      end
   end

   // Data registers carry no reset: contents are undefined until written
   always_ff @(posedge clk_sys) begin
      for (int c = 0; c < 2; c++) begin
         if (hostWrRise && wrChan_q[c]) begin
            inData_q[c] <= hostDataIn;
         end
      end
      if (slvWr && slvAddr == `HMP_ADDR_OUT_DATA_1) begin
         outData_q[0] <= slvWdata;
      end
      if (slvWr && slvAddr == `HMP_ADDR_OUT_DATA_2) begin
         outData_q[1] <= slvWdata;
      end
   end

   // Status registers, per channel
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_q[0] <= `HMP_STATUS_RESET;
         status_q[1] <= `HMP_STATUS_RESET;
      end else if (hwStandby) begin
         status_q[0] <= `HMP_STATUS_RESET;
         status_q[1] <= `HMP_STATUS_RESET;
      end else begin
         for (int c = 0; c < 2; c++) begin
            // Only user bits take slave writes
            if (slvWr && slvAddr == (c == 0 ? `HMP_ADDR_STATUS_1 : `HMP_ADDR_STATUS_2)) begin
               status_q[c][7:4] <= slvWdata[7:4];
               status_q[c][2] <= slvWdata[2];
            end
            if (hostWrRise && wrChan_q[c]) begin
               status_q[c][`HMP_BIT_CMD_DATA] <= wrAddr_q;
            end
            // Host set is written last so it wins a same-cycle slave clear
            if (slvRdFall && slvAddrPrev_q == (c == 0 ? `HMP_ADDR_IN_DATA_1 : `HMP_ADDR_IN_DATA_2)) begin
               status_q[c][`HMP_BIT_IN_FULL] <= 1'b0;
            end
            if (hostWrRise && wrChan_q[c]) begin
               status_q[c][`HMP_BIT_IN_FULL] <= 1'b1;
            end
            if (hostRdRise && rdChan_q[c] && !rdAddr_q) begin
               status_q[c][`HMP_BIT_OUT_FULL] <= 1'b0;
            end
            if (slvWrFall && slvAddrPrev_q == (c == 0 ? `HMP_ADDR_OUT_DATA_1 : `HMP_ADDR_OUT_DATA_2)) begin
               status_q[c][`HMP_BIT_OUT_FULL] <= 1'b1;
            end
         end
      end
   end

   // Slave read mux; unmapped addresses read zero
   always_comb begin
      case (slvAddr)
         `HMP_ADDR_SYS_CTRL: slvRdata = sysCtrl_q;
         `HMP_ADDR_HOST_CTRL: slvRdata = hostCtrl_q;
         `HMP_ADDR_SER_TMR_CTRL: slvRdata = serTmrCtrl_q;
         `HMP_ADDR_IN_DATA_1: slvRdata = inData_q[0];
         `HMP_ADDR_OUT_DATA_1: slvRdata = outData_q[0];
         `HMP_ADDR_STATUS_1: slvRdata = status_q[0];
         `HMP_ADDR_IN_DATA_2: slvRdata = inData_q[1];
         `HMP_ADDR_OUT_DATA_2: slvRdata = outData_q[1];
         `HMP_ADDR_STATUS_2: slvRdata = status_q[1];
         default: slvRdata = 8'h00;
      endcase
   end

   assign chan1FullIrq = status_q[0][`HMP_BIT_IN_FULL] & hostCtrl_q[`HMP_BIT_CH1_IRQ_EN];
   assign chan2FullIrq = status_q[1][`HMP_BIT_IN_FULL] & hostCtrl_q[`HMP_BIT_CH2_IRQ_EN];

   // Two-entry stream copy of host writes: the byte in bits 7:0 plus command flag in bit 8 of the entry, no channel
   // A host write while full is not stored here; hostWriteReady warns the host side in advance
   assign bufPush = hostWrRise && (wrChan_q != 2'h0) && (bufCount_q != 2'(`HMP_BUF_DEPTH));
   assign bufPop = inFifoValid && inFifoReady;
   assign inFifoValid = bufCount_q != 2'h0;
   assign hostWriteReady = bufCount_q != 2'(`HMP_BUF_DEPTH);
   assign inFifoData = {1'b0, bufData_q[bufRdPtr_q][7:0]};
   assign inFifoCmd = bufData_q[bufRdPtr_q][8];

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bufCount_q <= 2'h0;
         bufWrPtr_q <= 1'b0;
         bufRdPtr_q <= 1'b0;
         bufData_q[0] <= 9'h000;
         bufData_q[1] <= 9'h000;
      end else begin
         if (bufPush) begin
            bufData_q[bufWrPtr_q] <= {wrAddr_q, hostDataIn};
            bufWrPtr_q <= ~bufWrPtr_q;
         end
         if (bufPop) begin
            bufRdPtr_q <= ~bufRdPtr_q;
         end
         bufCount_q <= bufCount_q + 2'(bufPush) - 2'(bufPop);
      end
   end

endmodule : hmp_host_port

// *** dv/hmp_host_port_asserts.sv ***
// Pin-level assertions for the host mailbox port
`timescale 1ns/10ps
`include "hmp_regs.svh"
module hmp_host_port_asserts (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic hwStandby,
   input wire logic hostAddrLine,
   input wire logic chan1Select_n,
   input wire logic chan2Select_n,
   input wire logic hostReadStrobe_n,
   input wire logic hostWriteStrobe_n,
   input wire logic altHostWriteStrobe_n,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   input wire logic [15:0] slvAddr,
   input wire logic slvRd,
   input wire logic [7:0] slvRdata,
   input wire logic chan1FullIrq,
   input wire logic chan2FullIrq,
   input wire logic inFifoValid,
   input wire logic inFifoReady,
   input wire logic [8:0] inFifoData
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Both strobes high over the read, so no host set can race the clear
   sequence s_rd1;
      slvRd && slvAddr == `HMP_ADDR_IN_DATA_1 && hostWriteStrobe_n && altHostWriteStrobe_n
      ##1 !slvRd && slvAddr == `HMP_ADDR_IN_DATA_1 && hostWriteStrobe_n && altHostWriteStrobe_n;
   endsequence
   property p_oe; hostDataOe |-> !hostReadStrobe_n && (chan1Select_n != chan2Select_n); endproperty
   a_oe: assert property (p_oe) else $error("bus driven outside a read");
   property p_irq1; slvRd && slvAddr == `HMP_ADDR_STATUS_1 && chan1FullIrq |-> slvRdata[1]; endproperty
   a_irq1: assert property (p_irq1) else $error("irq1 without full flag");
   property p_irq2; slvRd && slvAddr == `HMP_ADDR_STATUS_2 && chan2FullIrq |-> slvRdata[1]; endproperty
   a_irq2: assert property (p_irq2) else $error("irq2 without full flag");
   property p_hst; hostDataOe && hostAddrLine && !chan1Select_n && chan1FullIrq |-> hostDataOut[1]; endproperty
   a_hst: assert property (p_hst) else $error("host status lacks full flag");
   property p_clr1; s_rd1 |=> !chan1FullIrq; endproperty
   a_clr1: assert property (p_clr1) else $error("full flag not cleared by read");
   property p_hold; inFifoValid && !inFifoReady && !hwStandby |=> inFifoValid && $stable(inFifoData); endproperty
   a_hold: assert property (p_hold) else $error("stalled word lost");
   property p_tag; inFifoValid |-> !inFifoData[8]; endproperty
   a_tag: assert property (p_tag) else $error("stream top bit set");
   property p_sby; hwStandby |=> !chan1FullIrq && !chan2FullIrq; endproperty
   a_sby: assert property (p_sby) else $error("standby left a request");
endmodule : hmp_host_port_asserts
bind hmp_host_port hmp_host_port_asserts u_chk (.*);

// *** dv/hmp_host_model.sv ***
// Host processor model on the parallel pins
`timescale 1ns/10ps
module hmp_host_model (
   input wire logic clk_sys,
   input wire logic alt,
   output logic hostAddrLine,
   output logic chan1Select_n,
   output logic chan2Select_n,
   output logic altChan2Select_n,
   output logic hostReadStrobe_n,
   output logic hostWriteStrobe_n,
   output logic altHostWriteStrobe_n,
   output logic [7:0] hostDataIn,
   input wire logic [7:0] hostDataOut
);
   logic [7:0] d = 8'h00;
   logic drv = 1'b0;
   // Released bus shows the inverse, never a stale byte
   assign hostDataIn = drv ? d : ~d;
   initial begin
      {hostAddrLine, chan1Select_n, chan2Select_n, altChan2Select_n} = 4'hF;
      {hostReadStrobe_n, hostWriteStrobe_n, altHostWriteStrobe_n} = 3'h7;
   end
   task automatic acc(input logic c2, input logic wr, input logic a, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk_sys) #2;
      {hostAddrLine, d, drv, chan1Select_n} = {a, wd, wr, c2};
      {chan2Select_n, altChan2Select_n} = !c2 ? 2'h3 : (alt ? 2'h2 : 2'h1);
      hostReadStrobe_n = wr;
      {hostWriteStrobe_n, altHostWriteStrobe_n} = !wr ? 2'h3 : (alt ? 2'h2 : 2'h1);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys) rd = hostDataOut;
      @(posedge clk_sys) #2 {hostReadStrobe_n, hostWriteStrobe_n, altHostWriteStrobe_n} = 3'h7;
      repeat (2) @(posedge clk_sys);
      #2 {chan1Select_n, chan2Select_n, altChan2Select_n, drv} = 4'hE;
   endtask : acc
endmodule : hmp_host_model

// *** dv/hmp_host_port_tb.sv ***
// Self-checking bench for the host mailbox port
`timescale 1ns/10ps
`include "hmp_regs.svh"
module hmp_host_port_tb import hmp_pkg::*; ;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic hwStandby = 1'b0, slvRd = 1'b0, slvWr = 1'b0, inFifoReady = 1'b0, alt = 1'b0;
   logic [15:0] slvAddr = 16'h0000;
   hmp_byte_t slvWdata = 8'h00, hostDataIn, hostDataOut, slvRdata, r;
   logic hostAddrLine, chan1Select_n, chan2Select_n, altChan2Select_n;
   logic hostReadStrobe_n, hostWriteStrobe_n, altHostWriteStrobe_n;
   logic hostDataOe, chan1FullIrq, chan2FullIrq, inFifoValid, inFifoCmd, hostWriteReady;
   logic [8:0] inFifoData;
   int failures = 0, compares = 0;
   always #25 clk_sys = ~clk_sys;
   hmp_host_port u_dut (.*);
   hmp_host_model u_host (.*);
   task automatic chk(input hmp_byte_t g, input hmp_byte_t e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic sw(input logic [15:0] a, input hmp_byte_t v);
      @(posedge clk_sys) #2 {slvAddr, slvWdata, slvWr} = {a, v, 1'b1};
      @(posedge clk_sys) #2 slvWr = 1'b0;
      @(posedge clk_sys);
   endtask : sw
   task automatic sr(input logic [15:0] a, input hmp_byte_t e);
      @(posedge clk_sys) #2 {slvAddr, slvRd} = {a, 1'b1};
      @(negedge clk_sys) r = slvRdata;
      @(posedge clk_sys) #2 slvRd = 1'b0;
      @(posedge clk_sys) #2 chk(r, e);
   endtask : sr
   task automatic hw(input logic c2, input logic a, input hmp_byte_t v);
      u_host.acc(c2, 1'b1, a, v, r);
   endtask : hw
   task automatic hr(input logic c2, input logic a, input hmp_byte_t e);
      u_host.acc(c2, 1'b0, a, 8'h00, r);
      chk(r, e);
   endtask : hr
   task automatic t_reset;
      sr(`HMP_ADDR_STATUS_1, 8'h00);
      sr(`HMP_ADDR_STATUS_2, 8'h00);
      sr(`HMP_ADDR_SER_TMR_CTRL, 8'h00);
      sw(`HMP_ADDR_SYS_CTRL, 8'h0B);
      sw(`HMP_ADDR_HOST_CTRL, 8'h06);
   endtask : t_reset
   // Receiver stalls through both writes, so the buffer must hold them
   task automatic t_in;
      hw(1'b0, 1'b1, 8'hA5);
      hw(1'b1, 1'b0, 8'h3C);
      chk({6'h0, chan2FullIrq, hostWriteReady}, 8'h02);
      hr(1'b0, 1'b1, 8'h0A);
      sr(`HMP_ADDR_STATUS_2, 8'h02);
      sw(`HMP_ADDR_HOST_CTRL, 8'h02);
      chk({6'h0, chan2FullIrq, chan1FullIrq}, 8'h01);
      sr(`HMP_ADDR_STATUS_1, 8'h0A);
      sr(`HMP_ADDR_IN_DATA_1, 8'hA5);
      sr(`HMP_ADDR_STATUS_1, 8'h08);
      sr(`HMP_ADDR_IN_DATA_2, 8'h3C);
      sr(`HMP_ADDR_STATUS_2, 8'h00);
      @(posedge clk_sys) #2 inFifoReady = 1'b1;
      @(negedge clk_sys) chk({inFifoValid, inFifoCmd, inFifoData[5:0]}, 8'hE5);
      @(negedge clk_sys) chk({inFifoValid, inFifoCmd, inFifoData[5:0]}, 8'hBC);
      @(negedge clk_sys) chk({6'h0, inFifoValid, hostWriteReady}, 8'h01);
   endtask : t_in
   task automatic t_out(input logic c2, input hmp_byte_t v, input hmp_byte_t b);
      sw(c2 ? `HMP_ADDR_OUT_DATA_2 : `HMP_ADDR_OUT_DATA_1, v);
      sr(c2 ? `HMP_ADDR_STATUS_2 : `HMP_ADDR_STATUS_1, b | 8'h01);
      hr(c2, 1'b1, b | 8'h01);
      hr(c2, 1'b0, v);
      sr(c2 ? `HMP_ADDR_STATUS_2 : `HMP_ADDR_STATUS_1, b);
   endtask : t_out
   task automatic t_user;
      sw(`HMP_ADDR_STATUS_1, 8'hFF);
      sr(`HMP_ADDR_STATUS_1, 8'hFC);
      hr(1'b0, 1'b1, 8'hFC);
      sw(`HMP_ADDR_STATUS_1, 8'h00);
      sr(`HMP_ADDR_STATUS_1, 8'h08);
   endtask : t_user
   task automatic t_pin;
      sw(`HMP_ADDR_SER_TMR_CTRL, 8'h08);
      alt = 1'b1;
      hw(1'b1, 1'b1, 8'h77);
      sr(`HMP_ADDR_STATUS_2, 8'h0A);
      sr(`HMP_ADDR_IN_DATA_2, 8'h77);
      alt = 1'b0;
      hw(1'b1, 1'b0, 8'h11);
      sr(`HMP_ADDR_STATUS_2, 8'h08);
      sw(`HMP_ADDR_SYS_CTRL, 8'h09);
      hw(1'b0, 1'b1, 8'h22);
      sr(`HMP_ADDR_STATUS_1, 8'h08);
      // Disabled port must leave the host bus undriven
      hr(1'b0, 1'b1, 8'h00);
   endtask : t_pin
   task automatic t_sby;
      @(posedge clk_sys) #2 hwStandby = 1'b1;
      @(posedge clk_sys) #2 hwStandby = 1'b0;
      sr(`HMP_ADDR_STATUS_1, 8'h00);
      sr(`HMP_ADDR_STATUS_2, 8'h00);
      sr(`HMP_ADDR_SER_TMR_CTRL, 8'h00);
   endtask : t_sby
   task automatic summarize;
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (4) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      t_reset();
      t_in();
      t_out(1'b0, 8'h5A, 8'h08);
      t_out(1'b1, 8'hC3, 8'h00);
      t_user();
      t_pin();
      t_sby();
      summarize();
   end
   // About eleven times the expected run
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule : hmp_host_port_tb
